// file: logic/bfpath_pkg.sv
// Package of constants for the breaker failure timing paths block
package bfpath_pkg;
   // ----------------------------------------------------------------
   // Time base
   // ----------------------------------------------------------------
   localparam int unsigned CLK_HZ        = 40000000;   // Reference clock
   localparam int unsigned TICK_US       = 1000;       // Timer resolution
   localparam int unsigned TICK_CYCLES   = CLK_HZ / 1000000 * TICK_US;
   localparam int          TICK_W        = 16;         // Prescaler width
   // ----------------------------------------------------------------
   // Setting widths and ranges
   // ----------------------------------------------------------------
   localparam int          DLY_W         = 16;         // Delay in ms
   localparam int          PU_W          = 12;         // Pickup, 0.01 pu
   localparam logic [DLY_W-1:0] DLY_MAX  = 16'hea60;   // 60.000 s
   localparam logic [PU_W-1:0]  PU_MIN   = 12'h001;    // 0.01 pu
   localparam logic [PU_W-1:0]  PU_MAX   = 12'hbb8;    // 30.00 pu
   // ----------------------------------------------------------------
   // Default settings
   // ----------------------------------------------------------------
   localparam logic [PU_W-1:0]  PU_DEF   = 12'h00a;    // 0.10 pu
   localparam logic [DLY_W-1:0] T1_DEF   = 16'h004b;   // 0.075 s
   localparam logic [DLY_W-1:0] T2_DEF   = 16'h0096;   // 0.150 s
   localparam logic [DLY_W-1:0] T3_DEF   = 16'h01f4;   // 0.500 s
   localparam logic [DLY_W-1:0] LS_DEF   = 16'h0000;   // 0.000 s
   localparam logic [DLY_W-1:0] DO_DEF   = 16'hafc8;   // 45.000 s
   localparam logic [DLY_W-1:0] DLY_ZERO = 16'h0000;   // Cleared count
   localparam logic [DLY_W-1:0] DLY_ONE  = 16'h0001;   // One tick
   localparam int          NPH           = 3;          // Phases
   // Low-set stage states
   typedef enum logic [1:0] {BFPATH_LS_IDLE, BFPATH_LS_RUN,
                             BFPATH_LS_DONE} bfpath_ls_t;
endpackage : bfpath_pkg

// file: logic/bfpath_top.sv
// Breaker failure timing paths for one bus source
`timescale 1ns/10ps
module bfpath_top
   import bfpath_pkg::*;
#(
   parameter int unsigned TICK_DIV = TICK_CYCLES   // Cycles per ms tick
) (
   input  wire logic              ref_clk,          // 40 MHz clock
   input  wire logic              sys_rst,          // Sync reset, high
   input  wire logic              bf_initiate,      // OR of initiates
   input  wire logic              seal_in_en,       // Seal-in enable
   input  wire logic              cur_sup_en,       // Current supervise
   input  wire logic              early_pos1_used,  // Early 1 assigned
   input  wire logic              early_pos2_used,  // Early 2 assigned
   input  wire logic              early_open_aux_contact1, // Open = 1
   input  wire logic              early_open_aux_contact2, // Open = 1
   input  wire logic              pos1_used,        // Aux 1 assigned
   input  wire logic              pos2_used,        // Aux 2 assigned
   input  wire logic              normal_aux_contact1, // Open = 1
   input  wire logic              normal_aux_contact2, // Open = 1
   input  wire logic              in_test1,         // In-test operand 1
   input  wire logic              in_test2,         // In-test operand 2
   input  wire logic              in_test1_failsafe,// Source 1 lost
   input  wire logic              in_test2_failsafe,// Source 2 lost
   input  wire logic [NPH-1:0]    ph_above_sup,     // I > sup pickup
   input  wire logic [NPH-1:0]    ph_above_hi,      // I > high-set
   input  wire logic [NPH-1:0]    ph_above_lo,      // I > low-set
   input  wire logic [DLY_W-1:0]  t1_dly_ms,        // Timer 1 delay
   input  wire logic [DLY_W-1:0]  t2_dly_ms,        // Timer 2 delay
   input  wire logic [DLY_W-1:0]  t3_dly_ms,        // Timer 3 delay
   input  wire logic [DLY_W-1:0]  ls_dly_ms,        // Low-set delay
   input  wire logic [DLY_W-1:0]  dropout_ms,       // Trip dropout
   output logic                   breaker_failure_op,   // Operate
   output logic                   breaker_failure_trip, // Sealed trip
   output logic                   path1_fail,       // Path 1 outcome
   output logic                   path2_fail,       // Path 2 outcome
   output logic                   path3_fail        // Path 3 outcome
);
   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic [TICK_W-1:0] tick_cnt_q;      // Millisecond prescaler
   logic              tick;            // One-cycle ms strobe
   logic              init_q;          // Previous initiation
   logic              seal_q;          // Sealed-in initiation
   logic [DLY_W-1:0]  t1_q;            // Timer 1 elapsed ms
   logic [DLY_W-1:0]  t2_q;            // Timer 2 elapsed ms
   logic [DLY_W-1:0]  t3_q;            // Timer 3 elapsed ms
   logic [DLY_W-1:0]  ls_q;            // Low-set elapsed ms
   logic [DLY_W-1:0]  do_q;            // Dropout remaining ms
   bfpath_ls_t        ls_st_q;         // Low-set stage state
   logic              p1_q;            // Path 1 failure
   logic              p2_q;            // Path 2 failure
   logic              p3_q;            // Path 3 failure
   logic              op_q;            // Operate register
   logic              trip_q;          // Trip register
   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   wire any_sup    = |ph_above_sup;
   wire any_hi     = |ph_above_hi;
   wire any_lo     = |ph_above_lo;
   // Seal-in keeps initiation alive while current flows
   wire init_raw   = bf_initiate | (seal_in_en & seal_q & any_sup);
   // Supervision lets timers 1, 2 and low-set run only with current above pickup
   wire init_act   = init_raw & (~cur_sup_en | any_sup);
   wire init_rise  = init_act & ~init_q;
   // Path 1 exists only if an early input is assigned
   wire p1_en      = early_pos1_used | early_pos2_used;
   wire early_open = (early_pos1_used & early_open_aux_contact1) |
                     (early_pos2_used & early_open_aux_contact2);
   // Path 3 exists only if an aux input is assigned
   wire p3_en      = pos1_used | pos2_used;
   wire aux_open   = (pos1_used & normal_aux_contact1) |
                     (pos2_used & normal_aux_contact2);
   // In-test block, failsafe-forced values ignored
   wire test_blk   = (in_test1 & ~in_test1_failsafe) |
                     (in_test2 & ~in_test2_failsafe);
   // Path 3 uses raw initiation, no undercurrent block
   wire p3_run     = init_raw & p3_en & ~test_blk;
   wire t1_exp     = (t1_q >= t1_dly_ms);
   wire t2_exp     = (t2_q >= t2_dly_ms);
   wire t3_exp     = (t3_q >= t3_dly_ms);
   wire ls_exp     = (ls_q >= ls_dly_ms);
   wire p1_d       = p1_en & init_act & t1_exp & ~early_open;
   wire p2_hi      = init_act & t2_exp & any_hi;
   wire p2_lo      = init_act & (ls_st_q == BFPATH_LS_DONE) & any_lo;
   wire p3_d       = p3_run & t3_exp & ~aux_open;
   wire op_d       = p1_d | p2_hi | p2_lo | p3_d;
   wire tick_wrap  = (tick_cnt_q == TICK_W'(TICK_DIV - 1));
   // ----------------------------------------------------------------
   // Millisecond time base
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (sys_rst | tick_wrap) begin
         tick_cnt_q <= '0;             // Restart prescaler
      end else begin
         tick_cnt_q <= tick_cnt_q + 1'b1;
      end
   end
   assign tick = tick_wrap;
   // ----------------------------------------------------------------
   // Initiation tracking and seal-in
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         init_q <= 1'b0;
         seal_q <= 1'b0;
      end else begin
         init_q <= init_act;
         seal_q <= init_raw;
      end
   end
   // ----------------------------------------------------------------
   // Timers 1 and 2: count ms while initiated, saturate
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (sys_rst | ~init_act | init_rise) begin
         t1_q <= DLY_ZERO;
         t2_q <= DLY_ZERO;
      end else if (tick) begin
         if (t1_q != DLY_MAX) t1_q <= t1_q + DLY_ONE;
         if (t2_q != DLY_MAX) t2_q <= t2_q + DLY_ONE;
      end
   end
   // ----------------------------------------------------------------
   // Timer 3: slow path
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (sys_rst | ~p3_run) begin
         t3_q <= DLY_ZERO;
      end else if (tick && t3_q != DLY_MAX) begin
         t3_q <= t3_q + DLY_ONE;
      end
   end
   // ----------------------------------------------------------------
   // Low-set stage after timer 2 expiry
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (sys_rst | ~init_act | init_rise) begin
         ls_st_q <= BFPATH_LS_IDLE;
         ls_q    <= DLY_ZERO;
      end else begin
         unique case (ls_st_q)
            BFPATH_LS_IDLE: begin      // Wait timer 2
               if (t2_exp) ls_st_q <= BFPATH_LS_RUN;
            end
            BFPATH_LS_RUN: begin       // Time low-set delay
               if (ls_exp) ls_st_q <= BFPATH_LS_DONE;
               else if (tick) ls_q <= ls_q + DLY_ONE;
            end
            BFPATH_LS_DONE: begin      // Hold until removal
               ls_st_q <= BFPATH_LS_DONE;
            end
            default: ls_st_q <= BFPATH_LS_IDLE;
         endcase
      end
   end
   // ----------------------------------------------------------------
   // Outcomes, operate and trip hold
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         p1_q <= 1'b0;
         p2_q <= 1'b0;
         p3_q <= 1'b0;
         op_q <= 1'b0;
      end else begin
         p1_q <= p1_d;
         p2_q <= p2_hi | p2_lo;
         p3_q <= p3_d;
         op_q <= op_d;
      end
   end
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         do_q   <= DLY_ZERO;
         trip_q <= 1'b0;
      end else if (op_d) begin
         do_q   <= dropout_ms;
         trip_q <= 1'b1;
      end else if (tick && do_q != DLY_ZERO) begin
         do_q   <= do_q - DLY_ONE;
         trip_q <= (do_q != DLY_ONE);
      end else if (do_q == DLY_ZERO) begin
         trip_q <= 1'b0;
      end
   end
   assign breaker_failure_op   = op_q;
   assign breaker_failure_trip = trip_q;
   assign path1_fail           = p1_q;
   assign path2_fail           = p2_q;
   assign path3_fail           = p3_q;
endmodule : bfpath_top

// file: tb/bfpath_assertions.sv
// Concurrent checks on the breaker failure timing path ports
`timescale 1ns/10ps
module bfpath_checker
   import bfpath_pkg::*;
(
   input wire logic ref_clk, sys_rst, bf_initiate, seal_in_en, cur_sup_en,
   input wire logic early_pos1_used, early_pos2_used, in_test1, in_test2,
   input wire logic early_open_aux_contact1, early_open_aux_contact2,
   input wire logic in_test1_failsafe, in_test2_failsafe,
   input wire logic [NPH-1:0]   ph_above_sup, ph_above_hi, ph_above_lo,
   input wire logic [DLY_W-1:0] t1_dly_ms, dropout_ms,
   input wire logic breaker_failure_op, breaker_failure_trip,
   input wire logic path1_fail, path2_fail, path3_fail
);
   // ----------------------------------------------------------------
   // Assertions and covers
   // ----------------------------------------------------------------
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   op_is_or_a:
      assert property (breaker_failure_op ==
         (path1_fail | path2_fail | path3_fail)) else $error("op not OR");
   trip_on_op_a:
      assert property (breaker_failure_op |-> breaker_failure_trip)
         else $error("op without trip");
   trip_hold_a:
      assert property ($fell(breaker_failure_trip) |-> $past(
         !breaker_failure_op) && (dropout_ms < 16'h0002 ||
         $past(!breaker_failure_op, 4))) else $error("trip dropped early");
   test_blocks_slow_a:
      assert property ((in_test1 && !in_test1_failsafe) || (in_test2 &&
         !in_test2_failsafe) |=> !path3_fail) else $error("path3 in test");
   no_early_path_a:
      assert property (!early_pos1_used && !early_pos2_used |=> !path1_fail)
         else $error("path1 without early input");
   unsup_gate_a:
      assert property (cur_sup_en && ph_above_sup == 3'h0 |=>
         !path1_fail && !path2_fail) else $error("path ran unsupervised");
   init_clear_a:
      assert property (!bf_initiate && !seal_in_en |=> !path1_fail &&
         !path2_fail && !path3_fail) else $error("path without initiate");
   zero_delay_a:
      assert property ($rose(bf_initiate) && t1_dly_ms == 16'h0000 &&
         !cur_sup_en && (early_pos1_used || early_pos2_used) &&
         !early_open_aux_contact1 && !early_open_aux_contact2 |->
         ##[1:2] path1_fail) else $error("zero delay path1 late");
   path2_cur_a:
      assert property ($rose(path2_fail) |-> $past((|ph_above_hi) |
         (|ph_above_lo))) else $error("path2 without current");
   cover property ($rose(path1_fail));
   cover property ($rose(path2_fail));
   cover property ($rose(path3_fail));
   cover property ($fell(breaker_failure_trip));
endmodule : bfpath_checker
bind bfpath_top bfpath_checker chk_i (.*);

// file: tb/bfpath_breaker_model.sv
// Breaker contacts and phase current detectors seen by the block
`timescale 1ns/10ps
module bfpath_breaker_model
   import bfpath_pkg::*;
(
   input  wire logic ref_clk, fault,
   input  wire logic [15:0] open_c, aux_c, lo_c,
   input  wire logic [NPH-1:0] ph_mask,
   output logic early_open_aux_contact1, early_open_aux_contact2,
   output logic normal_aux_contact1, normal_aux_contact2,
   output logic [NPH-1:0] ph_above_sup, ph_above_hi, ph_above_lo
);
   logic [15:0] cnt_q;  // Cycles since the fault began
   wire  main_shut = fault && cnt_q < open_c;  // Main contacts closed
   wire  lo_flow   = fault && cnt_q < lo_c;    // Resistor current flows
   // Count the fault time off the sampling edge
   always @(negedge ref_clk) cnt_q <= fault ? cnt_q + 16'h0001 : 16'h0000;
   assign early_open_aux_contact1 = !main_shut;
   assign early_open_aux_contact2 = !main_shut;
   assign normal_aux_contact1 = !(fault && cnt_q < aux_c);
   assign normal_aux_contact2 = !(fault && cnt_q < aux_c);
   assign ph_above_hi  = main_shut ? ph_mask : 3'h0;
   assign ph_above_lo  = lo_flow ? ph_mask : 3'h0;
   assign ph_above_sup = lo_flow ? ph_mask : 3'h0;
endmodule : bfpath_breaker_model

// file: tb/tb_breaker_failure_timing_paths.sv
// Self-checking bench of the breaker failure timing paths
`timescale 1ns/10ps
module tb_breaker_failure_timing_paths;
   import bfpath_pkg::*;
   localparam int TD = 4;  // Cycles per ms tick in simulation
   logic ref_clk = 0, sys_rst = 1, bf_initiate = 0, fault = 0, shrt = 0;
   logic seal_in_en = 0, cur_sup_en = 0, pos1_used = 0, pos2_used = 0;
   logic early_pos1_used = 0, early_pos2_used = 0, in_test1 = 0;
   logic in_test2 = 0, in_test1_failsafe = 0, in_test2_failsafe = 0;
   logic early_open_aux_contact1, early_open_aux_contact2;
   logic normal_aux_contact1, normal_aux_contact2, path1_fail, path2_fail;
   logic breaker_failure_op, breaker_failure_trip, path3_fail;
   logic [NPH-1:0] ph_above_sup, ph_above_hi, ph_above_lo, ph_mask = 3'h0;
   logic [DLY_W-1:0] t1_dly_ms = 0, t2_dly_ms = 0, t3_dly_ms = 0;
   logic [DLY_W-1:0] ls_dly_ms = 0, dropout_ms = 16'h0005;
   logic [15:0] open_c = 0, aux_c = 0, lo_c = 0;
   int fail_count = 0, num_checks = 0, seed = 1, cyc = 0, om, am, lm;
   always #12.5 ref_clk = ~ref_clk;
   bfpath_top #(.TICK_DIV(TD)) dut (.*);
   bfpath_breaker_model model (.*);
   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic int rnd(input int m);
      return $unsigned($random(seed)) % m;
   endfunction : rnd
   // Paths expected to fail, bit 0 is path 1
   // A zero delay expires in the first cycle of initiation, so even a
   // one-cycle initiate trips that path; otherwise the delay must end
   // while the raw (rt) or supervised (at) initiation still lasts
   function automatic logic [2:0] expect_paths();
      logic blk, a0, m;
      int   rt, at;  // Milliseconds the raw and supervised initiation last
      m   = (ph_mask != 0);
      blk = (in_test1 && !in_test1_failsafe) ||
            (in_test2 && !in_test2_failsafe);
      rt  = !shrt ? 1000 : (seal_in_en && m) ? lm : 0;
      at  = (cur_sup_en && m && lm < rt) ? lm : rt;
      a0  = !(cur_sup_en && !m);  // Supervised initiation seen at all
      return {(pos1_used | pos2_used) && !blk && am > t3_dly_ms &&
                 (t3_dly_ms == 0 || t3_dly_ms < rt),
              a0 && m && (((t2_dly_ms == 0 || t2_dly_ms < at) &&
                 om > t2_dly_ms) || (t2_dly_ms + ls_dly_ms < at &&
                 lm > t2_dly_ms + ls_dly_ms)),
              a0 && (early_pos1_used | early_pos2_used) &&
                 om > t1_dly_ms && (t1_dly_ms == 0 || t1_dly_ms < at)};
   endfunction : expect_paths
   task automatic chk(input logic got, input logic exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic summarize();
      if (fail_count == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : summarize
   // Random settings on a grid that keeps events off timer boundaries
   task automatic cfg_rand();
      {t1_dly_ms, t2_dly_ms, t3_dly_ms} = {16'(4 * rnd(5)),
         16'(4 * rnd(5)), 16'(4 * rnd(5))};
      ls_dly_ms = 16'(4 * rnd(3));
      om = 4 * rnd(7) + 2;
      am = 4 * rnd(7) + 2;
      lm = om + 4 * rnd(3);
      {early_pos1_used, early_pos2_used, pos1_used, pos2_used} = 4'(rnd(16));
      {in_test1, in_test2, in_test1_failsafe, in_test2_failsafe} = 4'(rnd(16));
      {seal_in_en, cur_sup_en, shrt, ph_mask} = 6'(rnd(64));
   endtask : cfg_rand
   // One initiation with the breaker opening at the chosen times
   task automatic run_case();
      logic s1, s2, s3, st;
      {s1, s2, s3, st} = 4'h0;
      open_c = 16'(om * TD);
      aux_c = 16'(am * TD);
      lo_c = 16'(lm * TD);
      fault = 1;
      bf_initiate = 1;
      repeat (160) begin
         @(negedge ref_clk);
         if (shrt) bf_initiate = 0;
         {s1, s2, s3} = {s1 | path1_fail, s2 | path2_fail, s3 | path3_fail};
         st = st | breaker_failure_trip;
      end
      chk(s1, expect_paths() >> 0 & 3'h1);
      chk(s2, expect_paths() >> 1 & 3'h1);
      chk(s3, expect_paths() >> 2 & 3'h1);
      chk(st, |expect_paths());
      bf_initiate = 0;
      fault = 0;
      repeat (48) @(negedge ref_clk);
      chk(breaker_failure_trip | path1_fail | path2_fail, 1'b0);
   endtask : run_case
   // ----------------------------------------------------------------
   // Main sequence and hang guard
   // ----------------------------------------------------------------
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 30000) begin
         fail_count++;
         summarize();
      end
   end
   initial begin
      repeat (12) @(negedge ref_clk);
      sys_rst = 0;
      cfg_rand();
      {pos1_used, in_test1, in_test1_failsafe, in_test2, shrt} = 5'h18;
      am = 30;
      run_case();
      {in_test1_failsafe, ph_mask, cur_sup_en} = 5'h10;
      run_case();
      {early_pos1_used, early_pos2_used, t1_dly_ms} = 18'h0;
      run_case();
      repeat (60) begin
         cfg_rand();
         run_case();
      end
      summarize();
   end
endmodule : tb_breaker_failure_timing_paths
